// [test/acmr_host.sv]
// host model of the byte register port: 16-bit writes and reads
// assumes the caller waits for reset release before its first access
`timescale 1ns/1ps
module acmr_host (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // callers keep volume codes below 68h unless probing silence
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d[15:8];
    @(posedge clock);
    reg_addr <= a | 8'h01;
    reg_wdata <= d[7:0];
    @(posedge clock);
    reg_wr <= 1'b0;
    // released data is inverted so a stale byte never looks valid
    reg_wdata <= ~d[7:0];
  endtask : wr16

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_addr <= a | 8'h01;
    #1;
    d[15:8] = reg_rdata;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d[7:0] = reg_rdata;
  endtask : rd16
endmodule : acmr_host

// [test/tb_top.sv]
// self-checking bench for the mixer register bank
// assumes the host model is the only driver of the register port
`timescale 1ns/1ps
module tb_top;
  import acmr_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } acmr_row_t;
  logic clock, arst_n, address_select_pin, full_compliance_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, link_quiesce, core_clock_stop, amp_powerdown_req;
  logic vra_enable, dra_enable;
  logic [NUM_CH-1:0][6:0] chan_atten;
  logic [NUM_CH-1:0] chan_silent;
  logic [3:0] bass_code, treble_code;
  logic [16:0] effective_rate;
  int n_errors = 0;
  int n_checks = 0;
  // ****
  // table: reset reads first, then writes with their read-back, plus two mirror-rate reads
  // ****
  acmr_row_t rows [28] = '{
    '{1'b0, ADDR_MASTER_VOL, 16'h0000, 16'h8000},
    '{1'b0, ADDR_TONE, 16'h0000, 16'h0f0f},
    '{1'b0, ADDR_PWRDN, 16'h0000, 16'h800e},
    '{1'b0, ADDR_EXT_CTRL, 16'h0000, 16'h01c0},
    '{1'b0, ADDR_FRONT_RATE, 16'h0000, 16'hbb80},
    '{1'b0, ADDR_SURR_RATE, 16'h0000, 16'hbb80},
    '{1'b0, ADDR_LFE_RATE, 16'h0000, 16'hbb80},
    '{1'b0, ADDR_IN_RATE_A, 16'h0000, 16'hbb80},
    '{1'b0, ADDR_IN_RATE_B, 16'h0000, 16'hbb80},
    '{1'b0, ADDR_LFE_CNT_VOL, 16'h0000, 16'h8080},
    '{1'b0, ADDR_SURR_VOL, 16'h0000, 16'h8080},
    '{1'b0, ADDR_EXT_ID, 16'h0000, 16'h01c3},
    '{1'b1, ADDR_MASTER_VOL, 16'h1234, 16'h1234},
    '{1'b1, ADDR_TONE, 16'h0a05, 16'h0a05},
    '{1'b1, ADDR_PWRDN, 16'h2005, 16'h200e},
    '{1'b1, ADDR_EXT_CTRL, 16'h0003, 16'h01c3},
    '{1'b1, ADDR_EXT_CTRL, 16'h03c0, 16'h01c0},
    '{1'b1, ADDR_EXT_ID, 16'hffff, 16'h01c3},
    '{1'b1, ADDR_FRONT_RATE, 16'hb3e2, 16'hbb80},
    '{1'b1, ADDR_FRONT_RATE, 16'hb3e1, 16'hac44},
    '{1'b1, ADDR_FRONT_RATE, 16'hffff, 16'hbb80},
    '{1'b1, ADDR_FRONT_RATE, 16'hac44, 16'hac44},
    '{1'b0, ADDR_SURR_RATE, 16'h0000, 16'hac44},
    '{1'b0, ADDR_LFE_RATE, 16'h0000, 16'hac44},
    '{1'b1, ADDR_IN_RATE_A, 16'h1234, 16'hbb80},
    '{1'b1, ADDR_LFE_CNT_VOL, 16'h1a2b, 16'h1a2b},
    '{1'b1, ADDR_SURR_VOL, 16'h8182, 16'h8182},
    '{1'b1, 8'h40, 16'h1234, 16'h0000}
  };

  acmr_regs #(.RESET_REG_ID(16'h00a5)) i_acmr_regs (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .address_select_pin(address_select_pin),
    .full_compliance_select(full_compliance_select), .chan_atten(chan_atten),
    .chan_silent(chan_silent), .bass_code(bass_code), .treble_code(treble_code),
    .link_quiesce(link_quiesce), .core_clock_stop(core_clock_stop),
    .amp_powerdown_req(amp_powerdown_req), .vra_enable(vra_enable),
    .dra_enable(dra_enable), .effective_rate(effective_rate));
  acmr_host i_acmr_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    i_acmr_host.rd16(a, v);
    chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, v});
  endtask : rc

  // outputs follow one edge after the committing write
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  task automatic chk_rst();
    chk("silent", 17'h0003f, {11'h000, chan_silent});
    chk("tone", 17'h000ff, {9'h000, bass_code, treble_code});
    chk("amp", 17'h00001, {16'h0000, amp_powerdown_req});
    chk("quiesce", 17'h00000, {16'h0000, link_quiesce});
    chk("rate", 17'h0bb80, effective_rate);
    chk("ext en", 17'h00000, {15'h0000, vra_enable, dra_enable});
    chk("clk stop", 17'h00000, {16'h0000, core_clock_stop});
  endtask : chk_rst

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    address_select_pin = 1'b0;
    full_compliance_select = 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk_rst();
    foreach (rows[i]) begin
      if (rows[i].wr) i_acmr_host.wr16(rows[i].addr, rows[i].wdata);
      rc(rows[i].addr, rows[i].exp);
    end
    // ****
    // hand-written cases
    // ****
    chk("bass", 17'h0000a, {13'h0000, bass_code});
    chk("treble", 17'h00005, {13'h0000, treble_code});
    i_acmr_host.wr16(ADDR_EXT_CTRL, 16'h0002);
    settle();
    chk("dra", 17'h15888, effective_rate);
    chk("ext en", 17'h00001, {15'h0000, vra_enable, dra_enable});
    i_acmr_host.wr16(ADDR_MASTER_VOL, 16'h7f45);
    settle();
    chk("fc left", 17'h0003f, {10'h000, chan_atten[0]});
    chk("fc right", 17'h00005, {10'h000, chan_atten[1]});
    @(posedge clock);
    full_compliance_select <= 1'b1;
    settle();
    chk("pr left", 17'h00068, {10'h000, chan_atten[0]});
    chk("pr right", 17'h00045, {10'h000, chan_atten[1]});
    chk("pr silent", 17'h00001, {15'h0000, chan_silent[1:0]});
    i_acmr_host.wr16(ADDR_MASTER_VOL, 16'hc523);
    i_acmr_host.wr16(ADDR_LFE_CNT_VOL, 16'h8203);
    i_acmr_host.wr16(ADDR_SURR_VOL, 16'h0485);
    settle();
    chk("silent", 17'h00027, {11'h000, chan_silent});
    chk("centre", 17'h00003, {10'h000, chan_atten[3]});
    chk("surr left", 17'h00004, {10'h000, chan_atten[4]});
    chk("lowfreq", 17'h00002, {10'h000, chan_atten[2]});
    chk("surr right", 17'h00005, {10'h000, chan_atten[5]});
    i_acmr_host.wr16(ADDR_PWRDN, 16'hf000);
    settle();
    chk("pd", 17'h00007, {14'h0000, amp_powerdown_req, core_clock_stop, link_quiesce});
    i_acmr_host.wr16(ADDR_PWRDN, 16'h0000);
    settle();
    chk("pd", 17'h00001, {14'h0000, amp_powerdown_req, core_clock_stop, link_quiesce});
    rc(ADDR_PWRDN, 16'h100e);
    rc(ADDR_RESET, 16'h00a5);
    i_acmr_host.wr16(ADDR_RESET, 16'h0000);
    settle();
    chk_rst();
    rc(ADDR_MASTER_VOL, 16'h8000);
    @(posedge clock);
    address_select_pin <= 1'b1;
    rc(ADDR_EXT_ID, 16'h41c3);
    i_acmr_host.wr16(ADDR_TONE, 16'h0102);
    @(posedge clock);
    arst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk_rst();
    @(posedge clock);
    arst_n <= 1'b1;
    rc(ADDR_TONE, 16'h0f0f);
    finish_test();
  end
endmodule : tb_top

// [verilog/acmr_pkg.sv]
// constants for the audio mixer control register bank
// assumes a byte-wide register port with 16-bit registers split hi/lo
package acmr_pkg;

  // ****************************************
  // byte addresses of the high bytes
  // ****************************************
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] ADDR_MASTER_VOL = 8'h02;
  localparam logic [7:0] ADDR_TONE = 8'h08;
  localparam logic [7:0] ADDR_PWRDN = 8'h26;
  localparam logic [7:0] ADDR_EXT_ID = 8'h28;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'h2a;
  localparam logic [7:0] ADDR_FRONT_RATE = 8'h2c;
  localparam logic [7:0] ADDR_SURR_RATE = 8'h2e;
  localparam logic [7:0] ADDR_LFE_RATE = 8'h30;
  localparam logic [7:0] ADDR_IN_RATE_A = 8'h32;
  localparam logic [7:0] ADDR_IN_RATE_B = 8'h34;
  localparam logic [7:0] ADDR_LFE_CNT_VOL = 8'h36;
  localparam logic [7:0] ADDR_SURR_VOL = 8'h38;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_MASTER_VOL = 16'h8000;
  localparam logic [15:0] RST_TONE = 16'h0f0f;
  localparam logic [15:0] RST_PWRDN = 16'h800e;
  localparam logic [15:0] RST_EXT_CTRL = 16'h01c0;
  localparam logic [15:0] RST_SIX_VOL = 16'h8080;

  // ****************************************
  // field positions and forced patterns
  // ****************************************
  localparam int MUTE_HI = 15;
  localparam int MUTE_LO = 7;
  localparam int PD_QUIESCE = 12;
  localparam int PD_CLK_STOP = 13;
  localparam int PD_AMP_REQ = 15;
  localparam logic [3:0] PD_LOW_FORCE = 4'he;
  localparam int EXT_VRA = 0;
  localparam int EXT_DRA = 1;
  localparam logic [3:0] EXT_READY = 4'h7;
  localparam int ID_CODEC_BIT = 14;
  localparam logic [15:0] EXT_ID_FEATURES = 16'h01c3;

  // ****************************************
  // volume and rate encodings
  // ****************************************
  localparam logic [6:0] VOL_INF_CODE = 7'h68;
  localparam logic [15:0] RATE_48K = 16'hbb80;
  localparam logic [15:0] RATE_44K = 16'hac44;
  // halfway between the two rates; a tie goes to the higher one
  localparam logic [15:0] RATE_MID = 16'hb3e2;
  localparam int NUM_CH = 6;

endpackage : acmr_pkg

// [verilog/acmr_regs.sv]
// audio mixer control register bank: volume, tone, power-down, rates
// assumes a byte register port in the core clock domain; the host
// writes the even (high) byte before the odd (low) byte of a register
//
// Behaviour
// - master bit 15 mutes both; left 14:8, right 6:0
// - full compliance uses six low bits, 1.5 dB
// - proprietary codes 0..68h, 68h is silence
// - master volume resets to 8000h
// - tone bass 11:8, treble 3:0, 1111 bypass
// - tone register resets to 0F0Fh
// - tone applies to front pair only
// - bit 12 quiesces link until reset
// - bit 13 requests core clock stop
// - bit 15 resets high, amplifier power-down request
// - power-down writes force low nibble to 1110
// - extended id is read only feature list
// - codec id reads address-select pin, upper zero
// - extended control bit0 variable rate, bit1 double
// - readiness bits 9:6 always stored as 0111
// - front rate snaps to nearest, tie higher
// - surround and lowfreq rates mirror front rate
// - double rate doubles effective sample rate
// - rates reset to BB80h, input rates fixed
// - six-channel fields with own mute bits
// - six-channel volumes reset to 8080h
// - any write to offset zero resets registers
// - high byte even address, low byte odd
`timescale 1ns/1ps
module acmr_regs
  import acmr_pkg::*;
#(
  // arbitrary value, returned when the reset register is read
  parameter logic [15:0] RESET_REG_ID = 16'h0055
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic address_select_pin,
  input wire logic full_compliance_select,
  output logic [NUM_CH-1:0][6:0] chan_atten,
  output logic [NUM_CH-1:0] chan_silent,
  output logic [3:0] bass_code,
  output logic [3:0] treble_code,
  output logic link_quiesce,
  output logic core_clock_stop,
  output logic amp_powerdown_req,
  output logic vra_enable,
  output logic dra_enable,
  output logic [16:0] effective_rate
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] hi_hold_r;
  logic [15:0] master_vol_r;
  logic [15:0] tone_r;
  logic [15:0] pwrdn_r;
  logic [15:0] ext_ctrl_r;
  logic [15:0] front_rate_r;
  logic [15:0] lfe_cnt_vol_r;
  logic [15:0] surr_vol_r;
  logic [7:0] reg_rdata_r;
  logic [NUM_CH-1:0][6:0] chan_atten_r;
  logic [NUM_CH-1:0] chan_silent_r;
  logic [3:0] bass_code_r;
  logic [3:0] treble_code_r;
  logic link_quiesce_r;
  logic core_clock_stop_r;
  logic amp_powerdown_req_r;
  logic vra_enable_r;
  logic dra_enable_r;
  logic [16:0] effective_rate_r;

  // ****************************************
  // write decode
  // ****************************************
  // a register changes only when its low byte lands, except that either byte written to offset zero resets them all; otherwise the pair is atomic
  wire [7:0] wr_base = {reg_addr[7:1], 1'b0};
  wire commit = reg_wr & reg_addr[0];
  wire [15:0] wr_word = {hi_hold_r, reg_wdata};
  wire soft_rst = reg_wr & (wr_base == ADDR_RESET);
  wire wr_master = commit & (wr_base == ADDR_MASTER_VOL);
  wire wr_tone = commit & (wr_base == ADDR_TONE);
  wire wr_pwrdn = commit & (wr_base == ADDR_PWRDN);
  wire wr_ext = commit & (wr_base == ADDR_EXT_CTRL);
  wire wr_rate = commit & (wr_base == ADDR_FRONT_RATE);
  wire wr_lfe_cnt = commit & (wr_base == ADDR_LFE_CNT_VOL);
  wire wr_surr = commit & (wr_base == ADDR_SURR_VOL);

  // quiesce bit only sets; resets are the sole way out
  wire [15:0] pwrdn_nxt = {wr_word[15:13], wr_word[PD_QUIESCE] | pwrdn_r[PD_QUIESCE],
                           wr_word[11:4], PD_LOW_FORCE};
  wire [15:0] ext_nxt = {wr_word[15:10], EXT_READY, wr_word[5:0]};
  wire [15:0] rate_nxt = (wr_word >= RATE_MID) ? RATE_48K : RATE_44K;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hi_hold_r <= 8'h00;
    end else if (reg_wr & ~reg_addr[0]) begin
      hi_hold_r <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      master_vol_r <= RST_MASTER_VOL;
      tone_r <= RST_TONE;
      lfe_cnt_vol_r <= RST_SIX_VOL;
      surr_vol_r <= RST_SIX_VOL;
    end else if (soft_rst) begin
      master_vol_r <= RST_MASTER_VOL;
      tone_r <= RST_TONE;
      lfe_cnt_vol_r <= RST_SIX_VOL;
      surr_vol_r <= RST_SIX_VOL;
    end else begin
      if (wr_master) master_vol_r <= wr_word;
      if (wr_tone) tone_r <= wr_word;
      if (wr_lfe_cnt) lfe_cnt_vol_r <= wr_word;
      if (wr_surr) surr_vol_r <= wr_word;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwrdn_r <= RST_PWRDN;
      ext_ctrl_r <= RST_EXT_CTRL;
      front_rate_r <= RATE_48K;
    end else if (soft_rst) begin
      pwrdn_r <= RST_PWRDN;
      ext_ctrl_r <= RST_EXT_CTRL;
      front_rate_r <= RATE_48K;
    end else begin
      if (wr_pwrdn) pwrdn_r <= pwrdn_nxt;
      if (wr_ext) ext_ctrl_r <= ext_nxt;
      if (wr_rate) front_rate_r <= rate_nxt;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  wire [15:0] ext_id_word = EXT_ID_FEATURES |
                            {1'b0, address_select_pin, 14'h0000};
  wire [7:0] rd_base = {reg_addr[7:1], 1'b0};
  // surround, lowfreq and input rates have no storage of their own
  wire [15:0] rd_word =
    (rd_base == ADDR_RESET) ? RESET_REG_ID :
    (rd_base == ADDR_MASTER_VOL) ? master_vol_r :
    (rd_base == ADDR_TONE) ? tone_r :
    (rd_base == ADDR_PWRDN) ? pwrdn_r :
    (rd_base == ADDR_EXT_ID) ? ext_id_word :
    (rd_base == ADDR_EXT_CTRL) ? ext_ctrl_r :
    (rd_base == ADDR_FRONT_RATE) ? front_rate_r :
    (rd_base == ADDR_SURR_RATE) ? front_rate_r :
    (rd_base == ADDR_LFE_RATE) ? front_rate_r :
    (rd_base == ADDR_IN_RATE_A) ? RATE_48K :
    (rd_base == ADDR_IN_RATE_B) ? RATE_48K :
    (rd_base == ADDR_LFE_CNT_VOL) ? lfe_cnt_vol_r :
    (rd_base == ADDR_SURR_VOL) ? surr_vol_r :
    16'h0000;
  wire [7:0] rd_byte = reg_addr[0] ? rd_word[7:0] : rd_word[15:8];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_byte;
    end
  end

  // ****************************************
  // channel volume decode
  // ****************************************
  // order: front left, front right, lowfreq, centre, surr left, surr right
  wire [NUM_CH-1:0][6:0] raw_code = {surr_vol_r[6:0], surr_vol_r[14:8],
                                     lfe_cnt_vol_r[6:0], lfe_cnt_vol_r[14:8],
                                     master_vol_r[6:0], master_vol_r[14:8]};
  wire [NUM_CH-1:0] raw_mute = {surr_vol_r[MUTE_LO], surr_vol_r[MUTE_HI],
                                lfe_cnt_vol_r[MUTE_LO], lfe_cnt_vol_r[MUTE_HI],
                                master_vol_r[MUTE_HI], master_vol_r[MUTE_HI]};
  wire fc_mode = ~full_compliance_select;
  logic [NUM_CH-1:0][6:0] atten_nxt;
  logic [NUM_CH-1:0] silent_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // undefined proprietary codes are pushed to silence, not left to chance
      wire over = ~fc_mode & (raw_code[gi] >= VOL_INF_CODE);
      assign silent_nxt[gi] = raw_mute[gi] | over;
      assign atten_nxt[gi] = fc_mode ? {1'b0, raw_code[gi][5:0]} :
                             (over ? VOL_INF_CODE : raw_code[gi]);
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chan_atten_r <= '0;
      chan_silent_r <= '1;
    end else begin
      chan_atten_r <= atten_nxt;
      chan_silent_r <= silent_nxt;
    end
  end

  // ****************************************
  // tone, power-down and rate outputs
  // ****************************************
  // tone codes feed the front pair stage only; other channels skip tone
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bass_code_r <= RST_TONE[11:8];
      treble_code_r <= RST_TONE[3:0];
    end else begin
      bass_code_r <= tone_r[11:8];
      treble_code_r <= tone_r[3:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link_quiesce_r <= 1'b0;
      core_clock_stop_r <= 1'b0;
      amp_powerdown_req_r <= 1'b1;
      vra_enable_r <= 1'b0;
      dra_enable_r <= 1'b0;
      effective_rate_r <= {1'b0, RATE_48K};
    end else begin
      link_quiesce_r <= pwrdn_r[PD_QUIESCE];
      core_clock_stop_r <= pwrdn_r[PD_CLK_STOP];
      amp_powerdown_req_r <= pwrdn_r[PD_AMP_REQ];
      vra_enable_r <= ext_ctrl_r[EXT_VRA];
      dra_enable_r <= ext_ctrl_r[EXT_DRA];
      effective_rate_r <= ext_ctrl_r[EXT_DRA] ? {front_rate_r, 1'b0}
                                              : {1'b0, front_rate_r};
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign chan_atten = chan_atten_r;
  assign chan_silent = chan_silent_r;
  assign bass_code = bass_code_r;
  assign treble_code = treble_code_r;
  assign link_quiesce = link_quiesce_r;
  assign core_clock_stop = core_clock_stop_r;
  assign amp_powerdown_req = amp_powerdown_req_r;
  assign vra_enable = vra_enable_r;
  assign dra_enable = dra_enable_r;
  assign effective_rate = effective_rate_r;

  // ****************************************
  // checks
  // ****************************************
  a_mute_both_silent : assert property (
    @(posedge clock) disable iff (!arst_n)
    master_vol_r[MUTE_HI] |=> chan_silent_r[0] && chan_silent_r[1])
    else $error("master mute did not silence front pair");

  a_fc_six_bits : assert property (
    @(posedge clock) disable iff (!arst_n)
    !full_compliance_select |=> chan_atten_r[0][6] == 1'b0 && chan_atten_r[1][6] == 1'b0)
    else $error("full compliance code used bit six");

  a_prop_over_silent : assert property (
    @(posedge clock) disable iff (!arst_n)
    full_compliance_select && master_vol_r[14:8] > VOL_INF_CODE
    |=> chan_silent_r[0] && chan_atten_r[0] == VOL_INF_CODE)
    else $error("undefined proprietary code not silent");

  a_pd_low_mask : assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_pwrdn && !soft_rst |=> pwrdn_r[3:0] == PD_LOW_FORCE && pwrdn_r[11:4] == $past(wr_word[11:4]))
    else $error("power-down write not masked");

  a_quiesce_sticky : assert property (
    @(posedge clock) disable iff (!arst_n)
    pwrdn_r[PD_QUIESCE] && !soft_rst |=> pwrdn_r[PD_QUIESCE] ##1 link_quiesce_r)
    else $error("link quiesce released without reset");

  a_ext_ready_bits : assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_ext |=> ext_ctrl_r[9:6] == EXT_READY)
    else $error("readiness bits not forced");

  a_rate_snap : assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_rate |=> front_rate_r == (($past(wr_word) >= RATE_MID) ? RATE_48K : RATE_44K))
    else $error("front rate not snapped");

  a_rate_mirror : assert property (
    @(posedge clock) disable iff (!arst_n)
    reg_rd && (rd_base == ADDR_SURR_RATE || rd_base == ADDR_LFE_RATE) && !reg_addr[0]
    |=> reg_rdata_r == $past(front_rate_r[15:8]))
    else $error("mirror rate read differs");

  a_dra_double : assert property (
    @(posedge clock) disable iff (!arst_n)
    ext_ctrl_r[EXT_DRA] |=> effective_rate_r == {$past(front_rate_r), 1'b0})
    else $error("double rate not applied");

  a_id_codec_bit : assert property (
    @(posedge clock) disable iff (!arst_n)
    reg_rd && rd_base == ADDR_EXT_ID && !reg_addr[0]
    |=> reg_rdata_r == {1'b0, $past(address_select_pin), 6'h01})
    else $error("codec identity byte wrong");

  a_soft_reset : assert property (
    @(posedge clock) disable iff (!arst_n)
    soft_rst |=> master_vol_r == RST_MASTER_VOL && tone_r == RST_TONE
      && surr_vol_r == RST_SIX_VOL && pwrdn_r == RST_PWRDN ##1 !link_quiesce_r)
    else $error("soft reset left a register changed");

  a_fc_low_bits : assert property (
    @(posedge clock) disable iff (!arst_n)
    !full_compliance_select |=> chan_atten_r[0] == {1'b0, $past(master_vol_r[13:8])}
      && chan_atten_r[1] == {1'b0, $past(master_vol_r[5:0])})
    else $error("full compliance code not the low six bits");

  a_prop_pass : assert property (
    @(posedge clock) disable iff (!arst_n)
    full_compliance_select && master_vol_r[6:0] < VOL_INF_CODE
    |=> chan_atten_r[1] == $past(master_vol_r[6:0]))
    else $error("proprietary code not passed through");

  a_tone_follow : assert property (
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> bass_code_r == $past(tone_r[11:8]) && treble_code_r == $past(tone_r[3:0]))
    else $error("tone codes do not follow the register");

  a_clock_stop : assert property (
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> core_clock_stop_r == $past(pwrdn_r[PD_CLK_STOP]))
    else $error("core clock stop does not follow its bit");

  a_amp_request : assert property (
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> amp_powerdown_req_r == $past(pwrdn_r[PD_AMP_REQ]))
    else $error("amplifier request does not follow its bit");

  a_ext_enables : assert property (
    @(posedge clock) disable iff (!arst_n)
    1'b1 |=> vra_enable_r == $past(ext_ctrl_r[EXT_VRA])
      && dra_enable_r == $past(ext_ctrl_r[EXT_DRA]))
    else $error("rate mode enables do not follow control");

  a_input_rate_fixed : assert property (
    @(posedge clock) disable iff (!arst_n)
    reg_rd && (rd_base == ADDR_IN_RATE_A || rd_base == ADDR_IN_RATE_B)
    |=> reg_rdata_r == ($past(reg_addr[0]) ? RATE_48K[7:0] : RATE_48K[15:8]))
    else $error("input rate register not fixed");

  a_six_mute : assert property (
    @(posedge clock) disable iff (!arst_n)
    lfe_cnt_vol_r[MUTE_HI] && surr_vol_r[MUTE_LO] |=> chan_silent_r[2] && chan_silent_r[5])
    else $error("six-channel mute bit ignored");

  a_six_reset : assert property (
    @(posedge clock) disable iff (!arst_n)
    soft_rst |=> lfe_cnt_vol_r == RST_SIX_VOL && surr_vol_r == RST_SIX_VOL
      ##1 chan_silent_r == 6'h3f)
    else $error("six-channel volumes not reset to muted");

  a_ext_id_low : assert property (
    @(posedge clock) disable iff (!arst_n)
    reg_rd && rd_base == ADDR_EXT_ID && reg_addr[0] |=> reg_rdata_r == EXT_ID_FEATURES[7:0])
    else $error("feature byte of identification wrong");

  a_even_holds : assert property (
    @(posedge clock) disable iff (!arst_n)
    reg_wr && !reg_addr[0] && !soft_rst
    |=> master_vol_r == $past(master_vol_r) && pwrdn_r == $past(pwrdn_r))
    else $error("even byte write changed a register");

endmodule : acmr_regs
